// ### rtl/spc_cfg.svh
// Constants for the self-programming flash control block.
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
`define SPC_CSR_IO_ADDR 6'h37
`define SPC_CSR_DATA_ADDR 8'h57
`define SPC_CSR_RESET 8'h00
`define SPC_BIT_IRQ_EN 7
`define SPC_BIT_BUSY 6
`define SPC_BIT_SIG 5
`define SPC_BIT_RRE 4
`define SPC_BIT_LOCK 3
`define SPC_BIT_PGWR 2
`define SPC_BIT_PGER 1
`define SPC_BIT_OPEN 0
`define SPC_CMD_FILL 5'h01
`define SPC_CMD_ERASE 5'h03
`define SPC_CMD_WRITE 5'h05
`define SPC_CMD_LOCK 5'h09
`define SPC_CMD_RRE 5'h11
`define SPC_STORE_WIN 3'h4
`define SPC_LOAD_WIN 3'h3
`define SPC_RWW_LAST 15'h6FFF
`define SPC_FLASH_LAST 15'h7FFF
`define SPC_RWW_PAGES 224
`define SPC_HALT_PAGES 32
`define SPC_PAGE_WORDS 128
`define SPC_BOOT_11 15'h7E00
`define SPC_BOOT_10 15'h7C00
`define SPC_BOOT_01 15'h7800
`define SPC_BOOT_00 15'h7000
`define SPC_PROG_TIME_US 4500
`define SPC_CLK_MHZ 25
`define SPC_PROG_CYCLES (`SPC_PROG_TIME_US * `SPC_CLK_MHZ)
`endif

// ### rtl/spc_pkg.sv
// Types shared by the self-programming flash control block.
package spc_pkg;
    // Store-program request from the core.
    typedef struct packed {
        logic valid;
        logic [15:0] ptr;
        logic [15:0] data;
    } spc_store_t;
    // Flash array command toward the flash macro.
    typedef struct packed {
        logic fill;
        logic erase;
        logic write;
        logic lock;
        logic discard;
        logic [8:0] page;
        logic [6:0] word;
        logic [15:0] data;
    } spc_flash_cmd_t;
    // Busy-interval states.
    typedef enum logic [1:0] {
        SPC_IDLE = 2'b00,
        SPC_ARMED = 2'b01,
        SPC_PROG = 2'b10
    } spc_state_t;
endpackage

// ### rtl/spc_timer.sv
// Down-counter used for arming windows and the programming interval.
`timescale 1ns/1ps
module spc_timer #(
    parameter int W = 20
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic clear,
    input wire logic [W-1:0] value,
    output logic running,
    output logic expire
);
    // Remaining cycles; zero means stopped.
    logic [W-1:0] count;

    // Expiry is the last cycle of a running count.
    assign running = (count != '0);
    assign expire = (count == {{(W-1){1'b0}}, 1'b1}) && !load && !clear;

    // Load wins over clear so a fresh command is never lost.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            count <= '0;
        else if (load)
            count <= value;
        else if (clear)
            count <= '0;
        else if (count != '0)
            count <= count - {{(W-1){1'b0}}, 1'b1};
    end
endmodule // spc_timer

// ### rtl/spc_ctrl.sv
// Self-programming control register and command sequencer.
// How it works
// R1 - Boot-size field picks boot start address.
// R2 - Low 224 pages readable, top 32 halting.
// R3 - 15-bit counter, 128-word pages.
// R4 - Page number from pointer bits 15:7.
// R5 - Pointer bits 7:1 select buffer word.
// R6 - Pointer bit 0 is load byte select.
// R7 - Ready interrupt while enabled and idle.
// R8 - Erase/write to readable region sets busy.
// R9 - Busy refuses readable region access.
// R10 - Re-enable after completion clears busy.
// R11 - Buffer load clears busy.
// R12 - Signature read serves load within three.
// R13 - Store during signature window does nothing.
// R14 - Re-enable store within four cycles.
// R15 - No re-enable while operation busy.
// R16 - Re-enable during load discards buffer.
// R17 - Software waits for enable bit zero.
// R18 - Only halting region fetches during programming.
// R19 - Software polls, masks interrupts, then stores.
// R20 - Software erases, fills, writes, re-enables.
// R21 - Software repeats re-enable until not busy.
// R22 - Register at 0x37, resets zero, busy read-only.
// R23 - Enable arms four cycles; alone fills buffer.
// R24 - Erase/write page, halt core if halting.
// R25 - Lock-set programs boot locks from low data.
// R26 - Unrecognised command patterns are ignored.
// R27 - Timer models erase/write busy interval.
// R28 - Down-counters track arming windows.
`timescale 1ns/1ps
`include "spc_cfg.svh"
module spc_ctrl
    import spc_pkg::*;
#(
    parameter int PROG_CYCLES = `SPC_PROG_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [5:0] io_addr,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire spc_store_t store,
    input wire logic load_req,
    input wire logic [15:0] load_ptr,
    input wire logic [7:0] sig_byte,
    output logic [7:0] sig_addr,
    output logic sig_hit,
    output logic [7:0] load_data,
    input wire logic global_irq_en,
    input wire logic [1:0] boot_size_field,
    input wire logic [14:0] fetch_pc,
    input wire logic flash_done,
    output spc_flash_cmd_t flash_cmd,
    output logic [7:0] lock_data,
    output logic [14:0] boot_start,
    output logic fetch_allowed,
    output logic rww_access_ok,
    output logic core_halt,
    output logic ready_irq
);
    // ==========================================================
    // Register fields
    // ==========================================================
    logic ready_irq_enable; // Interrupt enable bit.
    logic region_busy; // Readable region blocked.
    logic [4:0] cmd_bits; // Latched command of the low five bits.
    logic signature_read; // Signature read armed.
    logic prog_halting; // Current program targets halting region.
    logic filling; // Temporary buffer holds loaded words.
    spc_state_t state; // Sequencer state.
    spc_state_t next_state;

    // ==========================================================
    // Decode
    // ==========================================================
    wire csr_wr = io_wr && (io_addr == `SPC_CSR_IO_ADDR); // R22
    // The low five bits carry the command; the upper bits are flags.
    wire [4:0] wcmd = io_wdata[4:0];
    // Only the five known patterns are taken while idle.
    wire cmd_known = (wcmd == `SPC_CMD_FILL) || (wcmd == `SPC_CMD_ERASE)
        || (wcmd == `SPC_CMD_WRITE) || (wcmd == `SPC_CMD_LOCK)
        || (wcmd == `SPC_CMD_RRE); // R26
    wire sig_cmd = io_wdata[`SPC_BIT_SIG] && io_wdata[`SPC_BIT_OPEN]
        && (wcmd == `SPC_CMD_FILL);
    // Sequencer views used by the decode below.
    wire idle = (state == SPC_IDLE);
    wire arm = csr_wr && idle && (cmd_known || sig_cmd);
    wire operation_enable = (state != SPC_IDLE);
    wire armed = (state == SPC_ARMED);
    wire [8:0] page = store.ptr[15:7]; // R4
    wire [6:0] word = store.ptr[7:1]; // R5
    // A page counts as readable-during-write when its first word lies
    // at or below the region's last word; pointer bit 0 drops out.
    wire target_rww = ({page, 7'h00} >> 1) <= {1'b0, `SPC_RWW_LAST}; // R2
    // A store only acts while armed; the signature window swallows it.
    wire st = store.valid && armed && !signature_read; // R13
    // One decoded strobe per command, each a single-cycle pulse.
    wire do_fill = st && (cmd_bits == `SPC_CMD_FILL); // R23
    wire do_erase = st && (cmd_bits == `SPC_CMD_ERASE); // R24
    wire do_write = st && (cmd_bits == `SPC_CMD_WRITE); // R24
    wire do_lock = st && (cmd_bits == `SPC_CMD_LOCK); // R25
    wire do_rre = st && (cmd_bits == `SPC_CMD_RRE); // R14
    wire do_prog = do_erase || do_write;
    // Re-enable written while words sit in the buffer throws them away.
    wire discard = csr_wr && io_wdata[`SPC_BIT_RRE] && filling; // R16

    // ==========================================================
    // Timers
    // ==========================================================
    // Window and programming timer status.
    logic win_expire;
    logic prog_running;
    logic prog_expire;
    logic win_running;
    wire [2:0] win_len = sig_cmd ? `SPC_LOAD_WIN : `SPC_STORE_WIN;
    // Arming window restarts on every accepted command write.
    spc_timer #(.W(3)) u_win (
        .clk(clk),
        .resetn(resetn),
        .load(arm),
        .clear(st || (signature_read && load_req)),
        .value(win_len),
        .running(win_running),
        .expire(win_expire)
    ); // R28
    // Programming interval; a done strobe from flash ends it early.
    spc_timer #(.W(20)) u_prog (
        .clk(clk),
        .resetn(resetn),
        .load(do_prog),
        .clear(flash_done),
        .value(PROG_CYCLES[19:0]),
        .running(prog_running),
        .expire(prog_expire)
    ); // R27

    // ==========================================================
    // Sequencer
    // ==========================================================
    // Next-state choice; the window end drops the arm.
    // An unused window or a served load also returns to idle, so a
    // forgotten command never leaves the enable bit stuck high.
    always_comb
    begin
        next_state = state;
        unique case (state)
            SPC_IDLE:
                if (arm)
                    next_state = SPC_ARMED; // R23
            SPC_ARMED:
                if (do_prog)
                    next_state = SPC_PROG; // R27
                else if (st || win_expire || !win_running
                    || (signature_read && load_req))
                    next_state = SPC_IDLE; // R23
            SPC_PROG:
                if (prog_expire || flash_done || !prog_running)
                    next_state = SPC_IDLE; // R15
            default:
                next_state = SPC_IDLE;
        endcase
    end

    // State register.
    // The unused fourth code falls back to idle through the default.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state <= SPC_IDLE;
        else
            state <= next_state;
    end

    // Command field latch; cleared on return to idle so reads show zero.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cmd_bits <= 5'h00;
            signature_read <= 1'b0;
        end
        else if (arm)
        begin
            cmd_bits <= wcmd;
            signature_read <= sig_cmd; // R12
        end
        else if (next_state == SPC_IDLE)
        begin
            cmd_bits <= 5'h00;
            signature_read <= 1'b0;
        end
    end

    // Interrupt enable is plain read/write at any time.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ready_irq_enable <= 1'b0;
        else if (csr_wr)
            ready_irq_enable <= io_wdata[`SPC_BIT_IRQ_EN];
    end

    // Busy flag: set on programming start in the readable region wins over any clear.
    // Clearing needs a store, so it can only follow a finished operation.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            region_busy <= 1'b0;
        else if (do_prog && target_rww)
            region_busy <= 1'b1; // R8
        else if (do_rre || do_fill)
            region_busy <= 1'b0; // R10 R11
    end

    // Halting target and buffer occupancy tracking.
    // The halting flag is only read while programming, so it may go stale.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prog_halting <= 1'b0;
            filling <= 1'b0;
        end
        else
        begin
            if (do_prog)
                prog_halting <= !target_rww; // R24
            if (do_fill)
                filling <= 1'b1;
            else if (discard || do_write)
                filling <= 1'b0; // R16
        end
    end

    // ==========================================================
    // Flash command and load outputs
    // ==========================================================
    // Commands registered so data outputs come from flip-flops.
    // Page, word and data follow the store every cycle; only the strobes
    // say whether they matter, which saves an enable on the wide fields.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            flash_cmd <= '0;
            lock_data <= 8'h00;
        end
        else
        begin
            flash_cmd.fill <= do_fill;
            flash_cmd.erase <= do_erase;
            flash_cmd.write <= do_write;
            flash_cmd.lock <= do_lock;
            flash_cmd.discard <= discard;
            flash_cmd.page <= page;
            flash_cmd.word <= word;
            flash_cmd.data <= store.data;
            if (do_lock)
                lock_data <= store.data[7:0]; // R25
        end
    end

    // Signature load: pointer bit 0 is the byte select, kept whole.
    // The byte is captured so the core sees it one cycle after its load.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            load_data <= 8'h00;
            sig_hit <= 1'b0;
        end
        else
        begin
            sig_hit <= signature_read && armed && load_req; // R12
            if (signature_read && armed && load_req)
                load_data <= sig_byte;
        end
    end
    assign sig_addr = load_ptr[7:0]; // R6

    // ==========================================================
    // Status, access and interrupt
    // ==========================================================
    // Command bit 0 is shown as the live enable, not the latched bit.
    assign io_rdata = {ready_irq_enable, region_busy, signature_read,
        cmd_bits[4:1], operation_enable}; // R22
    // Boot start from the fuse field.
    assign boot_start = (boot_size_field == 2'b11) ? `SPC_BOOT_11 :
        (boot_size_field == 2'b10) ? `SPC_BOOT_10 :
        (boot_size_field == 2'b01) ? `SPC_BOOT_01 : `SPC_BOOT_00; // R1
    wire fetch_in_rww = (fetch_pc <= `SPC_RWW_LAST); // R3
    wire programming = (state == SPC_PROG);
    // Busy alone gates data access; programming also fences fetches.
    assign rww_access_ok = !region_busy; // R9
    assign fetch_allowed = !(programming || region_busy)
        || !fetch_in_rww; // R18
    // The core stops only for programming of the halting region.
    assign core_halt = programming && prog_halting; // R24
    // The request is a level that the core's interrupt logic samples.
    assign ready_irq = ready_irq_enable && global_irq_en
        && !operation_enable; // R7
endmodule // spc_ctrl

// ### bench/spc_ctrl_props.sv
// Checker tying the control block's outputs to their causes.
`timescale 1ns/1ps
module spc_ctrl_props
    import spc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [5:0] io_addr,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire spc_store_t store,
    input wire logic global_irq_en,
    input wire logic [14:0] fetch_pc,
    input wire spc_flash_cmd_t flash_cmd,
    input wire logic fetch_allowed,
    input wire logic rww_access_ok,
    input wire logic ready_irq
);
    // ==========
    // Properties, all on the one clock.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Decoded register views and the fields a store carries.
    wire csr_wr = io_wr && io_addr == 6'h37;
    wire idle = !io_rdata[0];
    wire busy = io_rdata[6];
    wire prog = flash_cmd.erase || flash_cmd.write;
    wire [8:0] st_page = store.ptr[15:7];
    wire [22:0] st_fill = {store.ptr[7:1], store.data};
    a_irq_level: assert property (
        ready_irq == (io_rdata[7] && global_irq_en && idle))
        else $error("ready irq level wrong");
    a_busy_blocks: assert property (busy |-> !rww_access_ok)
        else $error("busy region open");
    a_fetch_fence: assert property (
        busy && fetch_pc < 15'h7000 |-> !fetch_allowed)
        else $error("fetch from blocked region");
    a_busy_set: assert property (
        prog && flash_cmd.page < 9'h1C0 |-> busy)
        else $error("busy not set");
    a_page_pick: assert property (
        prog |-> flash_cmd.page == $past(st_page))
        else $error("page number wrong");
    a_fill_word: assert property (
        flash_cmd.fill |-> {flash_cmd.word, flash_cmd.data} == $past(st_fill))
        else $error("buffer word wrong");
    a_bad_pattern: assert property (
        csr_wr && idle && !(io_wdata[4:0] inside
        {5'h01, 5'h03, 5'h05, 5'h09, 5'h11}) |=> idle)
        else $error("unknown pattern armed");
    a_window_end: assert property (
        csr_wr && idle && io_wdata == 8'h01 ##1 !store.valid [*4]
        |-> ##[1:2] idle)
        else $error("window did not close");
    cover property (flash_cmd.erase);
    cover property (flash_cmd.fill);
    cover property (ready_irq);
endmodule // spc_ctrl_props
bind spc_ctrl spc_ctrl_props u_spc_ctrl_props (.*);

// ### bench/spc_core_model.sv
// Boot-loader core model issuing register writes and stores.
`timescale 1ns/1ps
module spc_core_model
    import spc_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] sig_addr,
    output logic [5:0] io_addr = 6'h00,
    output logic io_wr = 1'h0,
    output logic [7:0] io_wdata = 8'h00,
    output spc_store_t store = '0,
    output logic load_req = 1'h0,
    output logic [15:0] load_ptr = 16'h0000,
    output logic [7:0] sig_byte
);
    // ==========
    // Signature row stand-in: each byte is its address inverted.
    assign sig_byte = ~sig_addr;
    // One register write; stale data is scrambled once released.
    task automatic wr(input logic [5:0] a, input logic [7:0] c);
        io_addr = a;
        io_wdata = c;
        io_wr = 1'h1;
        @(negedge clk);
        io_wr = 1'h0;
        io_wdata = ~c;
    endtask
    // Store held one clock, then its fields scrambled.
    task automatic st(input logic [15:0] p, input logic [15:0] d);
        store = '{1'h1, p, d};
        @(negedge clk);
        store = '{1'h0, ~p, ~d};
    endtask
    // Write, then store gap clocks later; a gap of 5 is too late.
    task automatic cmd(input logic [7:0] c, input logic [15:0] p,
        input logic [15:0] d, input int gap);
        wr(6'h37, c);
        repeat (gap - 1) @(negedge clk);
        st(p, d);
    endtask
    // Signature read: a store inside the window, which must do nothing,
    // then the load one clock later, still inside the window.
    task automatic sig(input logic [15:0] p);
        wr(6'h37, 8'h21);
        st(p, 16'h0000);
        load_ptr = p;
        load_req = 1'h1;
        @(negedge clk);
        load_req = 1'h0;
        load_ptr = ~p;
    endtask
endmodule // spc_core_model

// ### bench/self_program_flash_control_tb_top.sv
// Self-checking bench for the self-programming control block.
`timescale 1ns/1ps
module self_program_flash_control_tb_top
    import spc_pkg::*;
;
    // ==========
    // Block wires, clock, scoreboard queue and random seed.
    logic clk = 1'h0, resetn = 1'h0, flash_done = 1'h0;
    logic io_wr, load_req, sig_hit, global_irq_en = 1'h0;
    logic fetch_allowed, rww_access_ok, core_halt, ready_irq;
    logic [5:0] io_addr;
    logic [7:0] io_wdata, io_rdata, sig_byte, sig_addr, load_data, lock_data;
    logic [1:0] boot_size_field = 2'h0;
    logic [14:0] fetch_pc = 15'h7F00, boot_start;
    logic [15:0] load_ptr, d;
    spc_store_t store;
    spc_flash_cmd_t flash_cmd;
    logic [35:0] expq[$], e;
    logic [14:0] bt[4] = '{15'h7000, 15'h7800, 15'h7C00, 15'h7E00};
    integer seed = 32'hAF4B4DA1;
    int n_errors = 0, n_tests = 0, n_discard = 0, i;
    wire [3:0] kind = {flash_cmd.fill, flash_cmd.erase,
        flash_cmd.write, flash_cmd.lock};
    wire [22:0] fill_seen = {flash_cmd.word, flash_cmd.data};
    always #20 clk = ~clk;
    spc_ctrl #(.PROG_CYCLES(20)) u_spc_ctrl (.*);
    spc_core_model u_spc_core_model (.*);
    task automatic check(input string w, input logic [31:0] s,
        input logic [31:0] x);
        n_tests++;
        if (s !== x)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", w, x, s);
        end
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Poll until idle; a stuck flag ends the run.
    task automatic wait_idle;
        int n;
        n = 0;
        while (io_rdata[0] !== 1'h0 && n < 99)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 99)
        begin
            n_errors++;
            tally_and_finish;
        end
    endtask
    // Note what the flash should see, then run the sequence.
    task automatic op(input logic [7:0] c, input logic [15:0] p,
        input int gap, input logic [3:0] k);
        wait_idle;
        d = 16'($random(seed));
        if (k != 4'h0)
            expq.push_back({k, p, d});
        u_spc_core_model.cmd(c, p, d, gap);
    endtask
    // Each flash command is matched with the oldest note, mid-cycle.
    always @(negedge clk)
    begin
        if (resetn && flash_cmd.discard === 1'h1)
            n_discard++;
        if (resetn && kind != 4'h0)
        begin
            e = expq.size() != 0 ? expq.pop_front() : 36'h0;
            check("kind", kind, e[35:32]);
            if (kind[3])
                check("fill", fill_seen, {e[23:17], e[15:0]});
            if (kind[2] | kind[1])
                check("page", flash_cmd.page, e[31:23]);
            if (kind[0])
                check("lock", lock_data, e[7:0]);
        end
    end
    initial
    begin
        repeat (6) @(negedge clk);
        resetn = 1'h1;
        check("csr", io_rdata, 8'h00);
        u_spc_core_model.wr(6'h36, 8'h01);
        check("unmapped", io_rdata[0], 1'h0);
        for (i = 0; i < 4; i++)
        begin
            boot_size_field = i[1:0];
            #1 check("boot", boot_start, bt[i]);
        end
        @(negedge clk);
        op(8'h03, 16'h0A00, 1, 4'h4);
        @(negedge clk);
        check("busy", {io_rdata[6], rww_access_ok}, 2'h2);
        fetch_pc = 15'h0100;
        #1 check("fetch", fetch_allowed, 1'h0);
        @(negedge clk);
        fetch_pc = 15'h7F00;
        // Repeat the re-enable until the busy flag reads clear.
        for (i = 0; i < 3 && io_rdata[6] !== 1'h0; i++)
            op(8'h11, 16'h0A00, 4, 4'h0);
        repeat (2) @(negedge clk);
        check("reopen", io_rdata[6], 1'h0);
        for (i = 0; i < 4; i++)
            op(8'h01, 16'h0A00 + 16'(2 * i), i + 1, 4'h8);
        op(8'h05, 16'h0A00, 2, 4'h2);
        @(negedge clk);
        check("busy", io_rdata[6], 1'h1);
        op(8'h01, 16'h0A02, 1, 4'h8);
        @(negedge clk);
        check("load", io_rdata[6], 1'h0);
        op(8'h11, 16'h0A00, 1, 4'h0);
        check("discard", n_discard, 1);
        op(8'h03, 16'hF000, 3, 4'h4);
        @(negedge clk);
        check("halt", {core_halt, io_rdata[6]}, 2'h2);
        op(8'h01, 16'h0000, 5, 4'h0);
        op(8'h07, 16'h0000, 1, 4'h0);
        check("ignored", io_rdata[0], 1'h0);
        op(8'h09, 16'h0001, 3, 4'h1);
        wait_idle;
        u_spc_core_model.sig(16'h0004);
        check("sig", {sig_hit, load_data}, 9'h1FB);
        wait_idle;
        u_spc_core_model.wr(6'h37, 8'h80);
        global_irq_en = 1'h1;
        #1 check("irq", ready_irq, 1'h1);
        @(negedge clk);
        global_irq_en = 1'h0;
        #1 check("irq", ready_irq, 1'h0);
        check("left", expq.size(), 0);
        tally_and_finish;
    end
endmodule // self_program_flash_control_tb_top
